/* design/smsc_pkg.sv */
// Shared constants for the switch MII and storm control register bank
package smsc_pkg;
    // ==========================================================
    // Register indices and byte addresses
    localparam logic [7:0]  IDX_MII_CTRL   = 8'h06;
    localparam logic [7:0]  IDX_STORM_LO   = 8'h07;
    localparam logic [7:0]  IDX_TEST_A     = 8'h08;
    localparam logic [7:0]  IDX_TEST_B     = 8'h09;
    localparam logic [7:0]  IDX_TEST_C     = 8'h0a;
    localparam logic [7:0]  IDX_STORM_STAT = 8'h10;
    localparam int          ADDR_SHIFT     = 2;

    // ==========================================================
    // Field positions of the switch MII control register
    localparam int BIT_BACKPRESSURE = 7;
    localparam int BIT_HALF_DUPLEX  = 6;
    localparam int BIT_FLOW_CTRL    = 5;
    localparam int BIT_SPEED_10M    = 4;
    localparam int BIT_NULL_VID     = 3;
    localparam int STORM_HI_MSB     = 2;
    localparam int STORM_W          = 11;
    localparam int REG_W            = 8;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_MII_CTRL = 8'h00;
    localparam logic [7:0] RST_STORM_LO = 8'h4a;
    localparam logic [7:0] RST_TEST_A   = 8'h24;
    localparam logic [7:0] RST_TEST_B   = 8'h28;
    localparam logic [7:0] RST_TEST_C   = 8'h24;

    // ==========================================================
    // Frame fields and storm block size
    localparam int          VID_W      = 12;
    localparam logic [11:0] NULL_VID   = 12'h000;
    localparam int          BLOCK_BITS = 6;

    // ==========================================================
    // Storm measurement periods
    localparam int CLK_HZ        = 50_000_000;
    localparam int PERIOD_100_MS = 50;
    localparam int PERIOD_10_MS  = 500;
    localparam int PERIOD_100_CYC = CLK_HZ / 1000 * PERIOD_100_MS;
    localparam int PERIOD_10_CYC  = CLK_HZ / 1000 * PERIOD_10_MS;

    // ==========================================================
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;
    localparam logic       HRESP_OKAY    = 1'b0;
endpackage

/* design/smsc_top.sv */
// Switch MII port control and broadcast storm limiter behind an AHB-Lite slave
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps

module smsc_top
    import smsc_pkg::*;
#(
    parameter int NUM_PORTS   = 5,
    parameter int P100_CYCLES = PERIOD_100_CYC,
    parameter int P10_CYCLES  = PERIOD_10_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    // Straps, sampled at the first edge after reset release
    input  wire logic                   duplex_strap_input,
    input  wire logic                   flow_control_strap_input,
    input  wire logic                   speed_strap_input,
    // Switch MII port configuration
    output logic                        mii_backpressure_en,
    output logic                        mii_half_duplex,
    output logic                        mii_flow_ctrl_en,
    output logic                        mii_speed_10m,
    // VLAN ID replacement path
    input  wire logic                   vid_valid,
    input  wire logic [VID_W-1:0]       vid_in,
    input  wire logic [VID_W-1:0]       port_vid,
    output logic                        vid_out_valid,
    output logic [VID_W-1:0]            vid_out,
    // Per-port broadcast byte strobes and port speed
    input  wire logic [NUM_PORTS-1:0]   bcast_byte,
    input  wire logic [NUM_PORTS-1:0]   port_is_10m,
    output logic [NUM_PORTS-1:0]        storm_drop
);

    localparam int P100_W = $clog2(P100_CYCLES);
    localparam int P10_W  = $clog2(P10_CYCLES);

    // ==========================================================
    // Register state
    logic [REG_W-1:0]     mii_ctrl_ff;
    logic [REG_W-1:0]     storm_lo_ff;
    logic [REG_W-1:0]     test_a_ff;
    logic [REG_W-1:0]     test_b_ff;
    logic [REG_W-1:0]     test_c_ff;
    logic                 strap_load_ff;
    logic                 hreadyout_ff;
    logic [31:0]          hrdata_ff;
    logic                 wr_pend_ff;
    logic [7:0]           wr_idx_ff;
    logic [STORM_W-1:0]   storm_limit;

    // Word index from a byte address
    function automatic logic [7:0] word_idx(input logic [31:0] a);
        word_idx = a[ADDR_SHIFT+7:ADDR_SHIFT];
    endfunction

    // ==========================================================
    // AHB address phase
    logic       addr_ok;
    logic [7:0] cur_idx;
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign cur_idx = word_idx(haddr);

    // Zero wait states, always OKAY; writes land in the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff   <= 1'b0;
            wr_idx_ff    <= 8'h00;
        end else begin
            hreadyout_ff <= 1'b1;
            if (hready) begin
                wr_pend_ff <= addr_ok && hwrite;
                wr_idx_ff  <= cur_idx;
            end
        end
    end

    // Read data captured at the end of the address phase; unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (cur_idx)
                IDX_MII_CTRL:   hrdata_ff <= {24'h00_0000, mii_ctrl_ff};
                IDX_STORM_LO:   hrdata_ff <= {24'h00_0000, storm_lo_ff};
                IDX_TEST_A:     hrdata_ff <= {24'h00_0000, test_a_ff};
                IDX_TEST_B:     hrdata_ff <= {24'h00_0000, test_b_ff};
                IDX_TEST_C:     hrdata_ff <= {24'h00_0000, test_c_ff};
                IDX_STORM_STAT: hrdata_ff <= {{(32-NUM_PORTS){1'b0}}, storm_drop};
                default:        hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hrdata    = hrdata_ff;
    assign hresp     = HRESP_OKAY;

    // ==========================================================
    // Strap capture: one cycle after release, straps load the control fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_load_ff <= 1'b1;
        end else begin
            strap_load_ff <= 1'b0;
        end
    end

    // Control register; a bus write cannot collide with strap load (no request that early)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mii_ctrl_ff <= RST_MII_CTRL;
        end else if (strap_load_ff) begin
            mii_ctrl_ff[BIT_HALF_DUPLEX] <= duplex_strap_input;
            mii_ctrl_ff[BIT_FLOW_CTRL]   <= flow_control_strap_input;
            mii_ctrl_ff[BIT_SPEED_10M]   <= speed_strap_input;
        end else if (wr_pend_ff && wr_idx_ff == IDX_MII_CTRL) begin
            mii_ctrl_ff <= hwdata[REG_W-1:0];
        end
    end

    // Storm limit low byte and factory test registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            storm_lo_ff <= RST_STORM_LO;
            test_a_ff   <= RST_TEST_A;
            test_b_ff   <= RST_TEST_B;
            test_c_ff   <= RST_TEST_C;
        end else if (wr_pend_ff) begin
            if (wr_idx_ff == IDX_STORM_LO) storm_lo_ff <= hwdata[REG_W-1:0];
            if (wr_idx_ff == IDX_TEST_A)   test_a_ff   <= hwdata[REG_W-1:0];
            if (wr_idx_ff == IDX_TEST_B)   test_b_ff   <= hwdata[REG_W-1:0];
            if (wr_idx_ff == IDX_TEST_C)   test_c_ff   <= hwdata[REG_W-1:0];
        end
    end

    // ==========================================================
    // Switch MII configuration outputs, straight from the control flop
    assign mii_backpressure_en = mii_ctrl_ff[BIT_BACKPRESSURE];
    assign mii_half_duplex     = mii_ctrl_ff[BIT_HALF_DUPLEX];
    assign mii_flow_ctrl_en    = mii_ctrl_ff[BIT_FLOW_CTRL];
    assign mii_speed_10m       = mii_ctrl_ff[BIT_SPEED_10M];

    // ==========================================================
    // Null VID replacement, one cycle of latency
    logic             vid_valid_ff;
    logic [VID_W-1:0] vid_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vid_valid_ff <= 1'b0;
            vid_ff       <= NULL_VID;
        end else begin
            vid_valid_ff <= vid_valid;
            if (vid_valid) begin
                if (mii_ctrl_ff[BIT_NULL_VID] && vid_in == NULL_VID) begin
                    vid_ff <= port_vid;
                end else begin
                    vid_ff <= vid_in;
                end
            end
        end
    end
    assign vid_out_valid = vid_valid_ff;
    assign vid_out       = vid_ff;

    // ==========================================================
    // Storm limit and period timers, one per port speed
    assign storm_limit = {mii_ctrl_ff[STORM_HI_MSB:0], storm_lo_ff};

    logic [P100_W-1:0] t100_ff;
    logic [P10_W-1:0]  t10_ff;
    logic              tick100_ff;
    logic              tick10_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            t100_ff    <= '0;
            tick100_ff <= 1'b0;
        end else if (t100_ff == P100_W'(P100_CYCLES - 1)) begin
            t100_ff    <= '0;
            tick100_ff <= 1'b1;
        end else begin
            t100_ff    <= t100_ff + 1'b1;
            tick100_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            t10_ff    <= '0;
            tick10_ff <= 1'b0;
        end else if (t10_ff == P10_W'(P10_CYCLES - 1)) begin
            t10_ff    <= '0;
            tick10_ff <= 1'b1;
        end else begin
            t10_ff    <= t10_ff + 1'b1;
            tick10_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Per-port block counting; block counters saturate so a long storm cannot wrap (byte counters wrap every block)
    logic [BLOCK_BITS-1:0] byte_cnt_ff [NUM_PORTS];
    logic [STORM_W-1:0]    blk_cnt_ff  [NUM_PORTS];
    logic [NUM_PORTS-1:0]  drop_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                byte_cnt_ff[p] <= '0;
                blk_cnt_ff[p]  <= '0;
            end
            drop_ff <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_is_10m[p] ? tick10_ff : tick100_ff) begin
                    byte_cnt_ff[p] <= '0;
                    blk_cnt_ff[p]  <= '0;
                    drop_ff[p]     <= 1'b0;
                end else begin
                    if (bcast_byte[p]) begin
                        byte_cnt_ff[p] <= byte_cnt_ff[p] + 1'b1;
                        if (&byte_cnt_ff[p] && ~&blk_cnt_ff[p]) begin
                            blk_cnt_ff[p] <= blk_cnt_ff[p] + 1'b1;
                        end
                    end
                    // Limit reached: later broadcast data is discarded
                    drop_ff[p] <= (blk_cnt_ff[p] >= storm_limit);
                end
            end
        end
    end
    assign storm_drop = drop_ff;

endmodule // smsc_top

/* bench/smsc_properties.sv */
// Concurrent checks on the ports of the switch MII and storm control bank
`timescale 1ns/1ps
module smsc_properties
    import smsc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        duplex_strap_input,
    input wire logic        flow_control_strap_input,
    input wire logic        speed_strap_input,
    input wire logic        mii_backpressure_en,
    input wire logic        mii_half_duplex,
    input wire logic        mii_flow_ctrl_en,
    input wire logic        mii_speed_10m,
    input wire logic        vid_valid,
    input wire logic        vid_out_valid
);
    // ==========================================================
    // Address phases decoded here, held through the data phase
    logic wr_ctl_ff;
    logic rd_ctl_ff;
    logic rd_bad_ff;
    logic take;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ctl_ff <= 1'b0;
            rd_ctl_ff <= 1'b0;
            rd_bad_ff <= 1'b0;
        end else begin
            wr_ctl_ff <= take && hwrite && haddr == 32'h0000_0018;
            rd_ctl_ff <= take && !hwrite && haddr == 32'h0000_0018;
            rd_bad_ff <= take && !hwrite && haddr == 32'h0000_002c; // Unmapped
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Control bits follow the word written in the data phase
    property p_wr_bp; wr_ctl_ff |=> mii_backpressure_en == $past(hwdata[7]); endproperty
    a_wr_bp: assert property (p_wr_bp) else $error("back pressure bit");
    property p_wr_dup; wr_ctl_ff |=> mii_half_duplex == $past(hwdata[6]); endproperty
    a_wr_dup: assert property (p_wr_dup) else $error("duplex bit");
    property p_wr_fc; wr_ctl_ff |=> mii_flow_ctrl_en == $past(hwdata[5]); endproperty
    a_wr_fc: assert property (p_wr_fc) else $error("flow control bit");
    property p_wr_spd; wr_ctl_ff |=> mii_speed_10m == $past(hwdata[4]); endproperty
    a_wr_spd: assert property (p_wr_spd) else $error("speed bit");
    // Straps land one edge after release; back pressure stays clear
    property p_strap;
        $fell(rst) |=> {mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en, mii_speed_10m}
            == {1'b0, $past({duplex_strap_input, flow_control_strap_input, speed_strap_input})};
    endproperty
    a_strap: assert property (p_strap) else $error("strap defaults");
    // Read data of the control word mirrors the live outputs
    property p_rdback;
        rd_ctl_ff |-> hrdata[31:4] == {24'h0, $past({mii_backpressure_en, mii_half_duplex,
            mii_flow_ctrl_en, mii_speed_10m})};
    endproperty
    a_rdback: assert property (p_rdback) else $error("control read back");
    property p_unmap; rd_bad_ff |-> hrdata == 32'h0000_0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_vid; vid_valid |=> vid_out_valid; endproperty
    a_vid: assert property (p_vid) else $error("vid answer missing");
endmodule // smsc_properties

bind smsc_top smsc_properties smsc_properties_i (.*);

/* bench/smsc_mac_model.sv */
// Far side model: sends bursts of broadcast bytes on one port
`timescale 1ns/1ps
module smsc_mac_model (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        go,
    input wire logic [2:0]  sport,
    output logic [4:0]      bcast_byte
);
    logic [7:0] left_ff;
    logic [2:0] port_ff;
    // Burst of 128 bytes so a period edge inside still leaves 64 on one side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_ff <= 8'h00;
            port_ff <= 3'h0;
        end else if (go) begin
            left_ff <= 8'h80;
            port_ff <= sport;
        end else if (left_ff != 8'h00) begin
            left_ff <= left_ff - 8'h01;
        end
    end
    assign bcast_byte = (left_ff != 8'h00) ? (5'h01 << port_ff) : 5'h00;
endmodule // smsc_mac_model

/* bench/smsc_top_bench.sv */
// Self-checking bench for the switch MII and storm control bank
`timescale 1ns/1ps
module smsc_top_bench;
    import smsc_pkg::*;
    localparam int P100 = 200;
    localparam int P10  = 2000;
    logic        clk, rst, hwrite, hready, hresp, go, vid_valid, vid_out_valid;
    logic        dup_s, fc_s, spd_s, bp, hd, fc, sp;
    logic [1:0]  htrans;
    logic [2:0]  sport;
    logic [31:0] haddr, hwdata, hrdata;
    logic [11:0] vid_in, port_vid, vid_out;
    logic [4:0]  bcast_byte, port_is_10m, storm_drop;
    int          fails, num_checks;
    logic [7:0]  ia [5] = '{IDX_STORM_LO, IDX_TEST_A, IDX_TEST_B, IDX_TEST_C, 8'h0b};
    logic [7:0]  ra [5] = '{RST_STORM_LO, RST_TEST_A, RST_TEST_B, RST_TEST_C, 8'h00};
    logic [7:0]  cp [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h07};
    smsc_top #(.P100_CYCLES(P100), .P10_CYCLES(P10)) smsc_top_i (
        .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .duplex_strap_input(dup_s), .flow_control_strap_input(fc_s),
        .speed_strap_input(spd_s), .mii_backpressure_en(bp), .mii_half_duplex(hd),
        .mii_flow_ctrl_en(fc), .mii_speed_10m(sp), .vid_valid(vid_valid),
        .vid_in(vid_in), .port_vid(port_vid), .vid_out_valid(vid_out_valid),
        .vid_out(vid_out), .bcast_byte(bcast_byte), .port_is_10m(port_is_10m),
        .storm_drop(storm_drop));
    smsc_mac_model smsc_mac_model_i (.clk(clk), .rst(rst), .go(go), .sport(sport),
        .bcast_byte(bcast_byte));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // One single AHB transfer; the wait on hready is cut only by the watchdog
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        haddr <= {22'h0, i, 2'b00};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
        #1;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, i, {24'h0, d}, x);
    endtask
    task automatic rdc(input string nm, input logic [7:0] i, input logic [7:0] e);
        logic [31:0] x;
        bus(1'b0, i, 32'h0, x);
        chk(nm, {24'h0, e}, x);
    endtask
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        {dup_s, fc_s, spd_s} <= s;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic vtest(input logic [11:0] vi, input logic [11:0] pv, input logic [11:0] e);
        @(posedge clk);
        vid_valid <= 1'b1;
        vid_in <= vi;
        port_vid <= pv;
        @(posedge clk);
        vid_valid <= 1'b0;
        #1;
        chk("vid", {20'h0, e}, {20'h0, vid_out});
    endtask
    // Burst on port p that must stay under the limit for a whole window
    task automatic quiet(input int p);
        int n;
        n = 0;
        @(posedge clk);
        sport <= p[2:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (400) begin
            @(posedge clk);
            if (storm_drop[p] !== 1'b0) n++;
        end
        chk("no drop", 32'h0, n);
    endtask
    // Burst on port p, wait for the drop flag, maybe read status, then time how long it stands
    task automatic srun(input int p, input int lo, input int hi, input logic rs);
        int n;
        n = 0;
        @(posedge clk);
        sport <= p[2:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (storm_drop[p] !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("drop rise", 32'h1, {31'h0, n < 400 && (!rs || n >= 60)});
        if (rs) rdc("stat", IDX_STORM_STAT, 8'h01 << p);
        n = 0;
        while (storm_drop[p] === 1'b1 && n < P10 + 50) begin
            @(posedge clk);
            n++;
        end
        chk("drop span", 32'h1, {31'h0, n >= lo && n <= hi});
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog sized well above the expected run
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400_000;
        fails++;
        wrap_up();
    end
    initial begin
        {rst, go, vid_valid, hwrite, htrans, sport, haddr, hwdata} = '0;
        {dup_s, fc_s, spd_s, vid_in, port_vid, port_is_10m} = '0;
        rst = 1'b1;
        fails = 0;
        num_checks = 0;
        do_reset(3'b101);
        rdc("ctl rst", IDX_MII_CTRL, 8'h50);
        for (int k = 0; k < 5; k++) rdc("rst val", ia[k], ra[k]);
        for (int k = 0; k < 5; k++) wr(ia[k], 8'ha5);
        for (int k = 0; k < 5; k++) rdc("rw", ia[k], (k == 4) ? 8'h00 : 8'ha5);
        for (int k = 0; k < 6; k++) begin
            wr(IDX_MII_CTRL, cp[k]);
            chk("mii", {28'h0, cp[k][7:4]}, {28'h0, bp, hd, fc, sp});
            rdc("ctl rw", IDX_MII_CTRL, cp[k]);
        end
        wr(IDX_MII_CTRL, 8'h08);
        vtest(12'h000, 12'h5a3, 12'h5a3);
        vtest(12'h123, 12'h5a3, 12'h123);
        wr(IDX_MII_CTRL, 8'h00);
        vtest(12'h000, 12'h5a3, 12'h000);
        // Limit 0x100 blocks: a burst of two blocks must not drop
        wr(IDX_MII_CTRL, 8'h01);
        wr(IDX_STORM_LO, 8'h00);
        quiet(0);
        chk("hi bits", 32'h0, {27'h0, storm_drop});
        wr(IDX_STORM_LO, 8'h01);
        wr(IDX_MII_CTRL, 8'h00);
        srun(0, 0, P100, 1'b0);
        srun(0, P100 - 100, P100, 1'b1);
        port_is_10m <= 5'h02;
        srun(1, 0, P10, 1'b0);
        srun(1, P10 - 100, P10, 1'b1);
        do_reset(3'b010);
        rdc("ctl rst2", IDX_MII_CTRL, 8'h20);
        rdc("lo rst2", IDX_STORM_LO, RST_STORM_LO);
        wrap_up();
    end
endmodule // smsc_top_bench
